/* dpfd_counter.sv */
// Purpose: One down-counter channel, delayed pulse or frequency divider
// Assumes: All inputs synchronous to clk; loads stable before go
// Notes:   Loads of zero are treated as one tick, except delays on the internal timebase, raised to MIN_DELAY_TICKS
module dpfd_counter
   import dpfd_pkg::*;
#(
   parameter int unsigned CNT_WIDTH = CNT_WIDTH_DEF
)(
   input  wire logic                         clk,
   input  wire logic                         reset,
   input  wire logic                         go_command,
   input  wire logic                         halt_command,
   input  wire logic                         divider_setup,
   input  wire logic [CNT_WIDTH-1:0]         delay_load,
   input  wire logic [CNT_WIDTH-1:0]         pulse_load,
   input  wire logic [CNT_WIDTH-1:0]         divisor_load,
   input  wire dpfd_pkg::dpfd_gate_type      gate_mode,
   input  wire dpfd_pkg::dpfd_outbeh_type    out_behavior,
   input  wire logic                         pulse_low_phase,
   input  wire logic                         use_source_pin,
   input  wire logic [dpfd_pkg::TB_SEL_WIDTH-1:0] timebase_select,
   input  wire logic [(1<<dpfd_pkg::TB_SEL_WIDTH)-1:0] timebase_in,
   input  wire logic                         source_pin,
   input  wire logic                         count_on_fall,
   input  wire logic                         gate_pin,
   output logic                              out_pin,
   output logic [CNT_WIDTH-1:0]              count_snapshot,
   output logic                              overflow,
   output logic                              running
);
   typedef struct packed {
      dpfd_state_type       state;
      logic [CNT_WIDTH-1:0] count;
      logic                 ovf;
      logic                 out;
      logic                 gate_prev;
      logic                 run;
   } dpfd_cnt_type;

   dpfd_cnt_type s_reg;
   dpfd_cnt_type s_next;
   dpfd_tick_if  tk ();

   logic                 gate_rise;
   logic                 gate_fall;
   logic                 trig;
   logic                 enable;
   logic                 retrig;
   logic                 edge_mode;
   logic [CNT_WIDTH-1:0] dly_eff;
   logic [CNT_WIDTH-1:0] pls_eff;
   logic [CNT_WIDTH-1:0] div_eff;
   logic                 idle_lvl;

   dpfd_edge_sel u_edge (
      .clk             (clk),
      .reset           (reset),
      .use_source_pin  (use_source_pin),
      .timebase_select (timebase_select),
      .timebase_in     (timebase_in),
      .source_pin      (source_pin),
      .count_on_fall   (count_on_fall),
      .tick_o          (tk.src)
   );

   always_comb begin
      gate_rise = ~s_reg.gate_prev & gate_pin;
      gate_fall = s_reg.gate_prev & ~gate_pin;
      trig      = (gate_mode == GATE_START_RISE ||
                   gate_mode == GATE_RETRIG_RISE) ? gate_rise : gate_fall;
      edge_mode = (gate_mode == GATE_START_RISE ||
                   gate_mode == GATE_START_FALL ||
                   gate_mode == GATE_RETRIG_RISE ||
                   gate_mode == GATE_RETRIG_FALL);
      retrig    = (gate_mode == GATE_RETRIG_RISE ||
                   gate_mode == GATE_RETRIG_FALL) && trig;
      case (gate_mode)
         GATE_LEVEL_HIGH: enable = gate_pin;
         GATE_LEVEL_LOW:  enable = ~gate_pin;
         default:         enable = 1'b1;
      endcase
      // Zero delay on the internal timebase is stretched, not skipped
      if (delay_load < CNT_WIDTH'(MIN_DELAY_TICKS) && !use_source_pin) begin
         dly_eff = CNT_WIDTH'(MIN_DELAY_TICKS);
      end else if (delay_load == '0) begin
         dly_eff = CNT_WIDTH'(1);
      end else begin
         dly_eff = delay_load;
      end
      pls_eff  = (pulse_load == '0) ? CNT_WIDTH'(1) : pulse_load;
      div_eff  = (divisor_load == '0) ? CNT_WIDTH'(1) : divisor_load;
      idle_lvl = divider_setup ? (out_behavior == OUT_LOW_PULSE ||
                                  out_behavior == OUT_LOW_TOGGLE)
                               : pulse_low_phase;

      s_next           = s_reg;
      s_next.gate_prev = gate_pin;
      if (go_command) begin
         s_next.ovf = 1'b0;
      end

      case (s_reg.state)
         ST_IDLE: begin
            s_next.out = idle_lvl;
            if (go_command) begin
               if (edge_mode) begin
                  s_next.state = ST_ARMED;
               end else if (divider_setup) begin
                  s_next.state = ST_DIV;
                  s_next.count = div_eff;
               end else begin
                  s_next.state = ST_DELAY;
                  s_next.count = dly_eff;
               end
            end
         end
         ST_ARMED: begin
            if (trig) begin
               s_next.state = divider_setup ? ST_DIV : ST_DELAY;
               s_next.count = divider_setup ? div_eff : dly_eff;
            end
         end
         ST_DELAY: begin
            s_next.out = pulse_low_phase;
            if (tk.tick && enable) begin
               if (s_reg.count == CNT_WIDTH'(1)) begin
                  s_next.state = ST_PULSE;
                  s_next.count = pls_eff;
                  s_next.out   = ~pulse_low_phase;
               end else begin
                  s_next.count = s_reg.count - CNT_WIDTH'(1);
               end
            end
         end
         ST_PULSE: begin
            s_next.out = ~pulse_low_phase;
            if (tk.tick && enable) begin
               if (s_reg.count == CNT_WIDTH'(1)) begin
                  // Retrigger modes re-arm; others finish the single pulse
                  s_next.state = retrig || (gate_mode == GATE_RETRIG_RISE ||
                                 gate_mode == GATE_RETRIG_FALL)
                                 ? ST_ARMED : ST_IDLE;
                  s_next.count = '0;
                  s_next.out   = pulse_low_phase;
               end else begin
                  s_next.count = s_reg.count - CNT_WIDTH'(1);
               end
            end
         end
         ST_DIV: begin
            if (tk.tick && enable) begin
               if (s_reg.count == CNT_WIDTH'(1)) begin
                  s_next.count = div_eff;
                  s_next.ovf   = 1'b1;
                  case (out_behavior)
                     OUT_HIGH_PULSE: s_next.out = 1'b1;
                     OUT_LOW_PULSE:  s_next.out = 1'b0;
                     default:        s_next.out = ~s_reg.out;
                  endcase
               end else begin
                  s_next.count = s_reg.count - CNT_WIDTH'(1);
                  if (out_behavior == OUT_HIGH_PULSE) begin
                     s_next.out = 1'b0;
                  end else if (out_behavior == OUT_LOW_PULSE) begin
                     s_next.out = 1'b1;
                  end
               end
            end
         end
         default: begin
            s_next.state = ST_IDLE;
         end
      endcase

      // Restart from the top of the sequence on each chosen gate edge
      if (retrig && s_reg.state != ST_IDLE) begin
         s_next.state = divider_setup ? ST_DIV : ST_DELAY;
         s_next.count = divider_setup ? div_eff : dly_eff;
      end

      // Halt has priority over every phase and over a simultaneous go
      if (halt_command) begin
         s_next.state = ST_IDLE;
         s_next.out   = idle_lvl;
      end

      // Kept as a flop so the status port carries no decode glitch
      s_next.run = (s_next.state != ST_IDLE);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_reg.state     <= ST_IDLE;
         s_reg.count     <= '0;
         s_reg.ovf       <= 1'b0;
         s_reg.out       <= 1'b0;
         s_reg.gate_prev <= 1'b0;
         s_reg.run       <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign out_pin        = s_reg.out;
   assign count_snapshot = s_reg.count;
   assign overflow       = s_reg.ovf;
   assign running        = s_reg.run;
endmodule // dpfd_counter

/* dpfd_pkg.sv */
// Purpose: Shared constants and types for the delayed pulse / divider counter
// Assumes: One clock, synchronous inputs
// Notes:   Codes are internal encodings of configuration ports
package dpfd_pkg;
   localparam int unsigned CNT_WIDTH_DEF  = 24;
   localparam int unsigned TB_SEL_WIDTH   = 2;
   localparam int unsigned MIN_DELAY_TICKS = 3;

   typedef enum logic [2:0] {
      GATE_IGNORED_SOFT_GO = 3'h0,
      GATE_LEVEL_HIGH      = 3'h1,
      GATE_LEVEL_LOW       = 3'h2,
      GATE_START_RISE      = 3'h3,
      GATE_START_FALL      = 3'h4,
      GATE_RETRIG_RISE     = 3'h5,
      GATE_RETRIG_FALL     = 3'h6
   } dpfd_gate_type;

   typedef enum logic [1:0] {
      OUT_HIGH_PULSE  = 2'h0,
      OUT_LOW_PULSE   = 2'h1,
      OUT_HIGH_TOGGLE = 2'h2,
      OUT_LOW_TOGGLE  = 2'h3
   } dpfd_outbeh_type;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_ARMED = 5'h02,
      ST_DELAY = 5'h04,
      ST_PULSE = 5'h08,
      ST_DIV   = 5'h10
   } dpfd_state_type;
endpackage

/* dpfd_tick_if.sv */
// Purpose: Carries the count tick from the edge selector to the counter
// Assumes: Single clock domain
// Notes:   Tick is a one-cycle pulse
interface dpfd_tick_if;
   logic tick;
   modport src (output tick);
   modport dst (input  tick);
endinterface

/* dpfd_edge_sel.sv */
// Purpose: Picks the count signal and turns its chosen edge into a tick
// Assumes: Source and timebases synchronous to clk
// Notes:   Edge detection costs one cycle of latency
module dpfd_edge_sel
   import dpfd_pkg::*;
(
   input  wire logic                         clk,
   input  wire logic                         reset,
   input  wire logic                         use_source_pin,
   input  wire logic [TB_SEL_WIDTH-1:0]      timebase_select,
   input  wire logic [(1<<TB_SEL_WIDTH)-1:0] timebase_in,
   input  wire logic                         source_pin,
   input  wire logic                         count_on_fall,
   dpfd_tick_if.src                          tick_o
);
   typedef struct packed {
      logic prev;
      logic tick;
   } dpfd_es_type;

   dpfd_es_type s_reg;
   dpfd_es_type s_next;
   logic        sel;

   always_comb begin
      sel = use_source_pin ? source_pin : timebase_in[timebase_select];
      s_next      = s_reg;
      s_next.prev = sel;
      s_next.tick = count_on_fall ? (s_reg.prev & ~sel)
                                  : (~s_reg.prev & sel);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick_o.tick = s_reg.tick;
endmodule // dpfd_edge_sel

/* dpfd_checker.sv */
// Purpose: Port assertions for dpfd_counter
// Assumes: One clock, async high reset
// Notes:   Gate history of three cycles covers tick latency
module dpfd_checker #(
   parameter int unsigned CNT_WIDTH = dpfd_pkg::CNT_WIDTH_DEF
)(
   input wire logic                    clk,
   input wire logic                    reset,
   input wire logic                    go_command,
   input wire logic                    halt_command,
   input wire logic                    divider_setup,
   input wire logic [CNT_WIDTH-1:0]    delay_load,
   input wire logic [CNT_WIDTH-1:0]    pulse_load,
   input wire dpfd_pkg::dpfd_gate_type gate_mode,
   input wire logic                    pulse_low_phase,
   input wire logic                    use_source_pin,
   input wire logic                    gate_pin,
   input wire logic                    out_pin,
   input wire logic [CNT_WIDTH-1:0]    count_snapshot,
   input wire logic                    overflow,
   input wire logic                    running
);
   timeunit 1ns;
   timeprecision 1ps;
   import dpfd_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_halt_stops_run: assert property (halt_command |=> !running)
      else $error("running after halt");
   a_go_starts_run: assert property (
      go_command && !halt_command && !running |=> running)
      else $error("go did not start");
   a_idle_count_still: assert property (
      !running && !$past(running) && !go_command |=> $stable(count_snapshot))
      else $error("count moved while idle");
   a_ovf_go_clear: assert property (
      go_command && !halt_command && !running |=> !overflow)
      else $error("overflow not cleared by go");
   a_ovf_sticky: assert property (overflow && !go_command |=> overflow)
      else $error("overflow dropped");
   a_delay_level: assert property (
      $rose(running) && !divider_setup && gate_mode < GATE_START_RISE
      |-> out_pin == pulse_low_phase)
      else $error("wrong delay level");
   a_delay_loaded: assert property (
      go_command && !halt_command && !running && !divider_setup &&
      use_source_pin && delay_load != 0 && gate_mode < GATE_START_RISE
      |=> count_snapshot == delay_load)
      else $error("delay count not loaded");
   a_pulse_loaded: assert property (
      running && $past(running) && !divider_setup && pulse_load != 0 &&
      gate_mode < GATE_START_RISE && $changed(out_pin)
      |-> count_snapshot == pulse_load)
      else $error("pulse count not loaded");
   a_level_hold: assert property (
      running && gate_mode == GATE_LEVEL_HIGH && !gate_pin &&
      !$past(gate_pin) && !$past(gate_pin, 2) && !$past(gate_pin, 3) &&
      !halt_command |=> $stable(count_snapshot))
      else $error("counted with gate inactive");
endmodule // dpfd_checker

/* dpfd_sig_model.sv */
// Purpose: Drives the source and gate pins
// Assumes: Source period of 2*HALF clocks, free running
// Notes:   Gate follows gate_lvl one clock late
module dpfd_sig_model #(
   parameter int HALF = 4
)(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic gate_lvl,
   output logic      source_pin,
   output logic      gate_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int n_reg;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         n_reg      <= 0;
         source_pin <= 1'b0;
         gate_pin   <= 1'b0;
      end else begin
         n_reg <= (n_reg == HALF - 1) ? 0 : n_reg + 1;
         if (n_reg == HALF - 1)
            source_pin <= !source_pin;
         gate_pin <= gate_lvl;
      end
   end
endmodule // dpfd_sig_model

/* dpfd_counter_tb.sv */
// Purpose: Self-checking bench for dpfd_counter
// Assumes: Source period of 8 clocks
// Notes:   Waits are bounded; a watchdog cuts a hang
module dpfd_counter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dpfd_pkg::*;
   logic clk = 1'b0, reset = 1'b1, go_command = 1'b0, halt_command = 1'b0;
   logic divider_setup = 1'b0, pulse_low_phase = 1'b0, use_source_pin = 1'b1;
   logic count_on_fall = 1'b0, gate_lvl = 1'b0, source_pin, gate_pin;
   logic out_pin, overflow, running;
   logic [23:0] delay_load = 24'h0, pulse_load = 24'h0, divisor_load = 24'h0;
   logic [23:0] count_snapshot;
   logic [1:0] timebase_select = 2'h0;
   logic [3:0] timebase_in;
   dpfd_gate_type gate_mode = GATE_IGNORED_SOFT_GO;
   dpfd_outbeh_type out_behavior = OUT_HIGH_PULSE;
   int mismatches = 0, n_compared = 0, cn = 0, t0, t1, t2, k;
   assign timebase_in = {4{source_pin}};
   initial forever #5 clk = ~clk;
   always @(posedge clk) cn <= cn + 1;
   dpfd_sig_model u_dpfd_sig_model (.clk, .reset, .gate_lvl, .source_pin,
      .gate_pin);
   dpfd_counter u_dpfd_counter (.clk, .reset, .go_command, .halt_command,
      .divider_setup, .delay_load, .pulse_load, .divisor_load, .gate_mode,
      .out_behavior, .pulse_low_phase, .use_source_pin, .timebase_select,
      .timebase_in, .source_pin, .count_on_fall, .gate_pin, .out_pin,
      .count_snapshot, .overflow, .running);
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Sync aligns go with the source so two runs compare exactly
   task automatic cmd(input bit h, input bit sync);
      do @(posedge clk); while (sync && cn % 8 != 0);
      if (h) halt_command <= 1'b1;
      else go_command <= 1'b1;
      @(posedge clk);
      halt_command <= 1'b0;
      go_command <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wchg(input bit w, output int t);
      logic v;
      v = w ? running : out_pin;
      for (int i = 0; i < 500 && (w ? running : out_pin) === v; i++)
         @(posedge clk);
      t = cn;
   endtask
   task automatic setup(input bit dv, input int d, input dpfd_gate_type m,
                        input bit p);
      @(posedge clk);
      divider_setup <= dv;
      delay_load <= 24'(d);
      pulse_load <= 24'h2;
      divisor_load <= 24'h3;
      gate_mode <= m;
      pulse_low_phase <= p;
      count_on_fall <= p;
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      mismatches++;
      end_of_test();
   end
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      for (k = 0; k < 2; k++) begin
         setup(0, 3, GATE_IGNORED_SOFT_GO, k[0]);
         cmd(0, 0);
         wchg(0, t0);
         cmp(out_pin, !k[0]);
         wchg(1, t1);
         cmp(t1 - t0, 16);
      end
      $display("test pulse done");
      setup(0, 20, GATE_IGNORED_SOFT_GO, 0);
      cmd(0, 0);
      repeat (30) @(posedge clk);
      cmd(1, 0);
      cmp(running, 0);
      $display("test halt done");
      use_source_pin <= 1'b0;
      timebase_select <= 2'h2;
      for (k = 3; k >= 0; k -= 3) begin
         setup(0, k, GATE_IGNORED_SOFT_GO, 0);
         cmd(0, 1);
         t2 = cn;
         wchg(0, t1);
         if (k == 3) t0 = t1 - t2;
         else cmp(t1 - t2, t0);
         wchg(1, t1);
      end
      $display("test zero delay done");
      use_source_pin <= 1'b1;
      for (k = 0; k < 4; k++) begin
         setup(1, 3, GATE_IGNORED_SOFT_GO, 0);
         out_behavior <= dpfd_outbeh_type'(k);
         repeat (3) @(posedge clk);
         cmd(0, 0);
         wchg(0, t0);
         cmp(out_pin, !k[0]);
         wchg(0, t1);
         wchg(0, t2);
         cmp(t2 - t0, k > 1 ? 48 : 24);
         cmp(overflow, 1);
         cmd(1, 0);
      end
      $display("test divider done");
      for (k = 1; k < 7; k++) begin
         setup(0, 4, dpfd_gate_type'(k), 0);
         gate_lvl <= !k[0];
         repeat (4) @(posedge clk);
         cmd(0, 0);
         repeat (60) @(posedge clk);
         cmp(out_pin, 0);
         if (k < 3) cmp(count_snapshot, 4);
         gate_lvl <= k[0];
         wchg(0, t0);
         cmp(out_pin, 1);
         cmd(1, 0);
      end
      $display("test gate done");
      setup(0, 4, GATE_RETRIG_RISE, 0);
      cmd(0, 0);
      gate_lvl <= 1'b1;
      repeat (12) @(posedge clk);
      gate_lvl <= 1'b0;
      repeat (8) @(posedge clk);
      gate_lvl <= 1'b1;
      repeat (16) @(posedge clk);
      cmp(out_pin, 0);
      wchg(0, t0);
      cmp(out_pin, 1);
      cmd(1, 0);
      $display("test retrigger done");
      end_of_test();
   end
endmodule // dpfd_counter_tb

bind dpfd_counter dpfd_checker #(.CNT_WIDTH(CNT_WIDTH)) u_dpfd_checker (
   .clk, .reset, .go_command, .halt_command, .divider_setup, .delay_load,
   .pulse_load, .gate_mode, .pulse_low_phase, .use_source_pin, .gate_pin,
   .out_pin, .count_snapshot, .overflow, .running);
